// ==== design/rca_pkg.sv ====
package rca_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;

    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_DELAY     = 8'h04;
    localparam logic [7:0]  OFS_SERIAL    = 8'h08;
    localparam logic [7:0]  OFS_SRCH      = 8'h0C;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [1:0]  TERM_PAGE     = 2'h1;

    localparam int          CTRL_SRC_LSB  = 0;
    localparam int          CTRL_PON      = 3;
    localparam int          CTRL_DIR_LSB  = 4;
    localparam int          CTRL_KEY_LSB  = 6;
    localparam logic [7:0]  CTRL_RST      = 8'h01;

    localparam logic [2:0]  SRC_KEYPAD    = 3'h0;
    localparam logic [2:0]  SRC_TERM1     = 3'h1;
    localparam logic [2:0]  SRC_TERM2     = 3'h2;
    localparam logic [2:0]  SRC_SERIAL    = 3'h3;
    localparam logic [2:0]  SRC_CARD      = 3'h5;

    localparam logic [1:0]  DIR_NO_FWD    = 2'h1;
    localparam logic [1:0]  DIR_NO_REV    = 2'h2;
    localparam logic [1:0]  KEY_LOC_REM   = 2'h2;

    localparam logic [7:0]  FN_FWD        = 8'h01;
    localparam logic [7:0]  FN_REV        = 8'h02;
    localparam logic [7:0]  FN_INCH_FWD   = 8'h04;
    localparam logic [7:0]  FN_INCH_REV   = 8'h05;
    localparam logic [7:0]  FN_PREMAG     = 8'h06;
    localparam logic [7:0]  FN_RUN_EN     = 8'h07;
    localparam logic [7:0]  FN_RST        = 8'h00;

    localparam int          DLY_W         = 14;
    localparam logic [13:0] DELAY_RST     = 14'h0064;
    localparam logic [13:0] DELAY_MAX     = 14'h2710;
    localparam int          DELAY_UNIT_NS = 10_000_000;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          TICK_CYCLES   = DELAY_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [7:0]  STATION_RST   = 8'h01;
    localparam logic [7:0]  STATION_MAX   = 8'hFA;
    localparam logic [3:0]  BAUD_RST      = 4'h3;
    localparam logic [1:0]  FRAME_RST     = 2'h0;
    localparam int          SRCH_PON_BIT  = 4;

endpackage

// ==== design/rca_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module rca_arbiter
    import rca_pkg::*;
#(
    parameter int N_TERM      = 11,
    parameter int TICK_CYC    = TICK_CYCLES
) (
    input  wire logic              clk_sys,             // System clock.
    input  wire logic              rst,                 // Sync reset.
    input  wire logic [ADDR_W-1:0] avs_address,         // Byte address.
    input  wire logic              avs_read,            // Read strobe.
    input  wire logic              avs_write,           // Write strobe.
    input  wire logic [DATA_W-1:0] avs_writedata,       // Write data.
    output logic      [DATA_W-1:0] avs_readdata,        // Read data.
    output logic                   avs_waitrequest,     // Stall.
    input  wire logic [N_TERM-1:0] term_pin,            // Terminal pins.
    input  wire logic              key_fwd_pin,         // Keypad forward.
    input  wire logic              key_rev_pin,         // Keypad reverse.
    input  wire logic              key_stop_pin,        // Keypad stop.
    input  wire logic              key_multi_pin,       // Function key.
    input  wire logic [2:0]        dig_run,             // Serial/bus/card run.
    input  wire logic [2:0]        dig_rev,             // Serial/bus/card dir.
    input  wire logic              trip_active,         // Core tripped.
    input  wire logic              trip_reset,          // Trip reset pulse.
    output logic                   run_cmd,             // Run request.
    output logic                   reverse_cmd,         // Reverse direction.
    output logic                   inch_fwd,            // Inch forward.
    output logic                   inch_rev,            // Inch reverse.
    output logic                   premag_cmd,          // Premagnetize.
    output logic                   speed_search_start,  // Search on start.
    output logic                   remote_ind,          // Remote shown.
    output logic      [2:0]        cmd_src_shown,       // Shown cmd source.
    output logic                   freq_src_keypad      // Freq src is keypad.
);

    localparam int TW = $clog2(TICK_CYC + 1);

    logic [7:0]        ctrl;
    logic [DLY_W-1:0]  dly_val;
    logic [7:0]        station;
    logic [3:0]        baud;
    logic [1:0]        frame;
    logic [7:0]        srch_cfg;
    logic [7:0]        term_fn [N_TERM];

    logic [N_TERM-1:0] term_s1;
    logic [N_TERM-1:0] term_s2;
    logic [3:0]        key_s1;
    logic [3:0]        key_s2;
    logic [3:0]        key_d;

    logic              remote;
    logic              kp_run;
    logic              kp_rev;
    logic              dig_hold;
    logic              pwr_lock;
    logic              trip_lock;
    logic              pon_start;
    logic              pu_arm;
    logic              pu_done;
    logic [TW-1:0]     tick_cnt;
    logic [DLY_W-1:0]  dly_cnt;

    // Register bus decode.
    wire              bus_req   = avs_read | avs_write;
    wire              bus_take  = bus_req & ~avs_waitrequest;
    wire              wr_take   = bus_take & avs_write;
    wire [3:0]        term_idx  = avs_address[5:2];
    wire              term_hit  = avs_address[7:6] == TERM_PAGE
                                  && int'(term_idx) < N_TERM;
    wire              wr_ctrl   = wr_take && avs_address == OFS_CTRL;
    wire              ctrl_ok   = wr_ctrl && avs_writedata[2:0] <= SRC_CARD;
    wire              wr_delay  = wr_take && avs_address == OFS_DELAY;
    wire              wr_serial = wr_take && avs_address == OFS_SERIAL;
    wire              wr_srch   = wr_take && avs_address == OFS_SRCH;
    wire              wr_term   = wr_take && term_hit;
    wire [DLY_W-1:0]  wr_dly    = avs_writedata[DLY_W-1:0];

    // Configuration fields.
    wire [2:0]        src       = ctrl[CTRL_SRC_LSB +: 3];
    wire              pon_en    = ctrl[CTRL_PON];
    wire [1:0]        dir_blk   = ctrl[CTRL_DIR_LSB +: 2];
    wire [1:0]        key_fn    = ctrl[CTRL_KEY_LSB +: 2];

    // Terminal function decode.
    logic [N_TERM-1:0] fx_bits;
    logic [N_TERM-1:0] rx_bits;
    logic [N_TERM-1:0] jf_bits;
    logic [N_TERM-1:0] jr_bits;
    logic [N_TERM-1:0] pm_bits;
    logic [N_TERM-1:0] en_bits;
    logic [N_TERM-1:0] en_asg;

    genvar gi;
    generate
        for (gi = 0; gi < N_TERM; gi++) begin : g_term
            assign fx_bits[gi] = term_s2[gi] && term_fn[gi] == FN_FWD;
            assign rx_bits[gi] = term_s2[gi] && term_fn[gi] == FN_REV;
            assign jf_bits[gi] = term_s2[gi] && term_fn[gi] == FN_INCH_FWD;
            assign jr_bits[gi] = term_s2[gi] && term_fn[gi] == FN_INCH_REV;
            assign pm_bits[gi] = term_s2[gi] && term_fn[gi] == FN_PREMAG;
            assign en_bits[gi] = term_s2[gi] && term_fn[gi] == FN_RUN_EN;
            assign en_asg[gi]  = term_fn[gi] == FN_RUN_EN;
        end
    endgenerate

    wire fx      = |fx_bits;
    wire rx      = |rx_bits;
    wire jf      = |jf_bits;
    wire jr      = |jr_bits;
    wire pm      = |pm_bits;
    wire run_any = fx | rx | jf | jr | pm;
    wire en_ok   = ~(|en_asg) | (|en_bits);

    // Keypad key edges, read from the second synchroniser stage.
    wire [3:0] key_edge  = key_s2 & ~key_d;
    wire       k_fwd     = key_edge[0];
    wire       k_rev     = key_edge[1];
    wire       k_stop    = key_edge[2];
    wire       k_multi   = key_edge[3];
    wire       lr_en     = key_fn == KEY_LOC_REM;
    wire       toggle    = lr_en & k_multi;
    wire       to_local  = toggle & remote;
    wire       to_remote = toggle & ~remote;
    wire       kp_active = ~remote | src == SRC_KEYPAD;

    // Source classes.
    wire       term_src  = src == SRC_TERM1 || src == SRC_TERM2;
    wire       dig_src   = src >= SRC_SERIAL && src <= SRC_CARD;
    wire [1:0] dig_idx   = 2'(src - SRC_SERIAL);
    wire       d_run     = dig_src & dig_run[dig_idx];
    wire       d_rev     = dig_rev[dig_idx];

    // Terminal command per mode.
    wire       t_req     = src == SRC_TERM2 ? fx
                                            : fx ^ rx;
    wire       t_rev     = rx;
    // The reset pulse itself locks, so a held input cannot slip through.
    wire       t_locked  = pwr_lock | trip_lock
                           | trip_reset;

    // Start delay runs on the request alone, never on direction.
    wire       tick      = tick_cnt == TW'(TICK_CYC - 1);
    wire       dly_act   = term_src & t_req;
    wire       dly_done  = dly_cnt >= dly_val;
    wire       dly_ok    = run_cmd | dly_done;

    // Command selection.
    logic cmd_req;
    logic cmd_rev;
    always_comb begin
        cmd_req = 1'b0;
        cmd_rev = 1'b0;
        if (!remote) begin
            cmd_req = kp_run & en_ok;
            cmd_rev = kp_rev;
        end else if (src == SRC_KEYPAD) begin
            cmd_req = kp_run;
            cmd_rev = kp_rev;
        end else if (term_src) begin
            cmd_req = t_req & ~t_locked & dly_ok;
            cmd_rev = t_rev;
        end else if (dig_src) begin
            cmd_req = d_run & ~dig_hold;
            cmd_rev = d_rev;
        end
    end

    wire blocked  = cmd_rev ? dir_blk == DIR_NO_REV
                            : dir_blk == DIR_NO_FWD;
    wire next_run = pu_done & ~trip_active & cmd_req
                    & ~blocked;
    wire inch_ok  = remote & term_src & ~t_locked & pu_done
                    & ~trip_active & ~run_cmd;
    wire next_jf  = inch_ok & jf & dir_blk != DIR_NO_FWD;
    wire next_jr  = inch_ok & jr & dir_blk != DIR_NO_REV;
    wire start    = next_run & ~run_cmd;
    wire next_ss  = start & pon_start & srch_cfg[SRCH_PON_BIT];

    // Read multiplexer.
    wire [DATA_W-1:0] status_word = {21'h0, cmd_src_shown, 1'b0,
                                     pon_start, dly_act & ~dly_done,
                                     trip_lock, pwr_lock, reverse_cmd,
                                     run_cmd, remote};
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (term_hit)
            rd_mux = {24'h0, term_fn[term_idx]};
        else if (avs_address == OFS_CTRL)
            rd_mux = {24'h0, ctrl};
        else if (avs_address == OFS_DELAY)
            rd_mux = {18'h0, dly_val};
        else if (avs_address == OFS_SERIAL)
            rd_mux = {18'h0, frame, baud, station};
        else if (avs_address == OFS_SRCH)
            rd_mux = {24'h0, srch_cfg};
        else if (avs_address == OFS_STATUS)
            rd_mux = status_word;
    end

    // Bus slave: one wait cycle per access.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req & avs_waitrequest)
                avs_readdata <= avs_read ? rd_mux : '0;
        end
    end

    // Configuration registers; an accepted control write also arms the power-up capture of pwr_lock and pon_start.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl     <= CTRL_RST;
            dly_val  <= DELAY_RST;
            station  <= STATION_RST;
            baud     <= BAUD_RST;
            frame    <= FRAME_RST;
            srch_cfg <= 8'h00;
        end else begin
            if (ctrl_ok)
                ctrl <= avs_writedata[7:0];
            if (wr_delay)
                dly_val <= wr_dly > DELAY_MAX ? DELAY_MAX : wr_dly;
            if (wr_serial) begin
                if (avs_writedata[7:0] <= STATION_MAX)
                    station <= avs_writedata[7:0];
                baud  <= avs_writedata[11:8];
                frame <= avs_writedata[13:12];
            end
            if (wr_srch)
                srch_cfg <= avs_writedata[7:0];
        end
    end

    generate
        for (gi = 0; gi < N_TERM; gi++) begin : g_fn
            always_ff @(posedge clk_sys) begin
                if (rst)
                    term_fn[gi] <= FN_RST;
                else if (wr_term && int'(term_idx) == gi)
                    term_fn[gi] <= avs_writedata[7:0];
            end
        end
    endgenerate

    // Pin synchronisers and key edge stage.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            term_s1 <= '0;
            term_s2 <= '0;
            key_s1  <= 4'h0;
            key_s2  <= 4'h0;
            key_d   <= 4'h0;
        end else begin
            term_s1 <= term_pin;
            term_s2 <= term_s1;
            key_s1  <= {key_multi_pin, key_stop_pin, key_rev_pin,
                        key_fwd_pin};
            key_s2  <= key_s1;
            key_d   <= key_s2;
        end
    end

    // Power-up capture waits for the first accepted control write, so the
    // terminal functions and the power-on setting are loaded when it looks.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pu_arm    <= 1'b0;
            pu_done   <= 1'b0;
            pwr_lock  <= 1'b0;
            pon_start <= 1'b0;
        end else begin
            if (ctrl_ok)
                pu_arm <= 1'b1;
            if (!pu_done && pu_arm) begin
                pu_done   <= 1'b1;
                pwr_lock  <= ~pon_en & run_any;
                pon_start <= pon_en & term_src & t_req;
            end else begin
                if (!run_any)
                    pwr_lock <= 1'b0;
                if (start || !t_req || !term_src)
                    pon_start <= 1'b0;
            end
        end
    end

    // Local/remote state and keypad latch.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            remote <= 1'b1;
            kp_run <= 1'b0;
            kp_rev <= 1'b0;
        end else begin
            if (!lr_en)
                remote <= 1'b1;
            else if (toggle)
                remote <= ~remote;
            if (toggle || k_stop || trip_active)
                kp_run <= 1'b0;
            else if (kp_active && (k_fwd || k_rev)) begin
                kp_run <= 1'b1;
                kp_rev <= k_rev;
            end
        end
    end

    // Lockouts for digital sources and trip reset.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dig_hold  <= 1'b0;
            trip_lock <= 1'b0;
        end else begin
            if (to_remote && dig_src)
                dig_hold <= 1'b1;
            else if (!d_run)
                dig_hold <= 1'b0;
            if (trip_reset && remote && run_any)
                trip_lock <= 1'b1;
            else if (!run_any)
                trip_lock <= 1'b0;
        end
    end

    // Start delay prescaler and counter.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt <= '0;
            dly_cnt  <= '0;
        end else if (!dly_act) begin
            tick_cnt <= '0;
            dly_cnt  <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
            if (tick && !dly_done)
                dly_cnt <= dly_cnt + DLY_W'(1);
        end
    end

    // Registered outputs.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_cmd            <= 1'b0;
            reverse_cmd        <= 1'b0;
            inch_fwd           <= 1'b0;
            inch_rev           <= 1'b0;
            premag_cmd         <= 1'b0;
            speed_search_start <= 1'b0;
            remote_ind         <= 1'b1;
            cmd_src_shown      <= CTRL_RST[2:0];
            freq_src_keypad    <= 1'b0;
        end else begin
            run_cmd            <= next_run;
            if (next_run)
                reverse_cmd <= cmd_rev;
            inch_fwd           <= next_jf & ~next_jr;
            inch_rev           <= next_jr & ~next_jf;
            premag_cmd         <= inch_ok & pm;
            speed_search_start <= next_ss;
            remote_ind         <= remote;
            cmd_src_shown      <= remote ? src : SRC_KEYPAD;
            freq_src_keypad    <= ~remote;
        end
    end

endmodule
`default_nettype wire

// ==== bench/rca_arbiter_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rca_arbiter_monitor (
    input wire logic       clk_sys,            // Clock.
    input wire logic       rst,                // Reset.
    input wire logic       avs_read,           // Read strobe.
    input wire logic       avs_write,          // Write strobe.
    input wire logic       avs_waitrequest,    // Stall.
    input wire logic       trip_active,        // Trip level.
    input wire logic       run_cmd,            // Run request.
    input wire logic       speed_search_start, // Search pulse.
    input wire logic       remote_ind,         // Remote shown.
    input wire logic [2:0] cmd_src_shown,      // Shown source.
    input wire logic       freq_src_keypad     // Keypad freq.
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer late");
    property p_ready_req;
        $fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write);
    endproperty
    a_ready_req: assert property (p_ready_req) else $error("stray answer");
    property p_ss_run;
        speed_search_start |-> run_cmd && !$past(run_cmd);
    endproperty
    a_ss_run: assert property (p_ss_run) else $error("bad search");
    property p_ss_pulse;
        speed_search_start |=> !speed_search_start;
    endproperty
    a_ss_pulse: assert property (p_ss_pulse) else $error("long search");
    property p_freq_local;
        freq_src_keypad != remote_ind;
    endproperty
    a_freq_local: assert property (p_freq_local) else $error("freq src");
    property p_local_src;
        !remote_ind |-> cmd_src_shown == 3'h0;
    endproperty
    a_local_src: assert property (p_local_src) else $error("cmd src");
    property p_local_stop;
        $fell(remote_ind) |-> ##2 !run_cmd [*2];
    endproperty
    a_local_stop: assert property (p_local_stop) else $error("no stop");
    property p_trip_stop;
        trip_active [*2] |-> !run_cmd;
    endproperty
    a_trip_stop: assert property (p_trip_stop) else $error("trip run");
    c_run: cover property ($rose(run_cmd));
    c_local: cover property ($fell(remote_ind));
    c_trip: cover property ($rose(trip_active));
endmodule
bind rca_arbiter rca_arbiter_monitor i_mon (.clk_sys(clk_sys), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .trip_active(trip_active),
    .run_cmd(run_cmd), .speed_search_start(speed_search_start),
    .remote_ind(remote_ind), .cmd_src_shown(cmd_src_shown),
    .freq_src_keypad(freq_src_keypad));
`default_nettype wire

// ==== bench/rca_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rca_panel_model (
    input  wire logic        clk_sys,  // Clock.
    output logic      [10:0] term_pin, // Terminal levels.
    output logic      [3:0]  key_pin,  // Fwd, rev, stop, function key.
    output logic      [2:0]  dig_run,  // Host run levels.
    output logic      [2:0]  dig_rev   // Host direction levels.
);
    initial begin
        term_pin = 11'h000;
        key_pin  = 4'h0;
        dig_run  = 3'h0;
        dig_rev  = 3'h0;
    end
    // Terminal levels stay until the next change.
    task automatic term(input logic [10:0] v);
        term_pin <= v;
        @(posedge clk_sys);
    endtask
    // A press is held long enough to pass the edge filter.
    task automatic press(input int k);
        key_pin[k] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        key_pin[k] <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic host(input logic [2:0] r, input logic [2:0] d);
        dig_run <= r;
        dig_rev <= d;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rca_pkg::*;
;
    logic        clk_sys;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        trip_active;
    logic        trip_reset;
    logic        run_cmd;
    logic        reverse_cmd;
    logic        remote_ind;
    logic [2:0]  cmd_src_shown;
    logic        freq_src_keypad;
    logic        inch_fwd;
    logic        inch_rev;
    logic        premag_cmd;
    logic        speed_search_start;
    logic [10:0] term_pin;
    logic [3:0]  key_pin;
    logic [2:0]  dig_run;
    logic [2:0]  dig_rev;
    logic [31:0] q;
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          ss_cnt = 0;
    rca_arbiter #(.TICK_CYC(4)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .term_pin(term_pin), .key_fwd_pin(key_pin[0]),
        .key_rev_pin(key_pin[1]), .key_stop_pin(key_pin[2]),
        .key_multi_pin(key_pin[3]), .dig_run(dig_run), .dig_rev(dig_rev),
        .trip_active(trip_active), .trip_reset(trip_reset),
        .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .inch_fwd(inch_fwd),
        .inch_rev(inch_rev), .premag_cmd(premag_cmd),
        .speed_search_start(speed_search_start),
        .remote_ind(remote_ind), .cmd_src_shown(cmd_src_shown),
        .freq_src_keypad(freq_src_keypad));
    rca_panel_model i_prt (.clk_sys(clk_sys), .term_pin(term_pin),
        .key_pin(key_pin), .dig_run(dig_run), .dig_rev(dig_rev));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    always @(posedge clk_sys)
        if (speed_search_start === 1'b1)
            ss_cnt <= ss_cnt + 1;
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Request holds until waitrequest is sampled low, then drops.
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= we;
        avs_read      <= !we;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        w(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        ck(q, e);
    endtask
    initial begin
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        trip_active = 1'b0;
        trip_reset = 1'b0;
        w(10);
        rst <= 1'b0;
        w(2);
        rd(OFS_CTRL, 32'h1);
        rd(OFS_DELAY, 32'h64);
        rd(OFS_SERIAL, 32'h301);
        rd(8'h20, 32'h0);
        rd(8'h83, 32'h0);
        wr(OFS_CTRL, 32'h6);
        rd(OFS_CTRL, 32'h1);
        wr(OFS_SERIAL, 32'hFB);
        rd(OFS_SERIAL, 32'h1);
        wr(OFS_SERIAL, 32'h3FA);
        rd(OFS_SERIAL, 32'h3FA);
        wr(OFS_SRCH, 32'hFFFF_FFFF);
        rd(OFS_SRCH, 32'hFF);
        wr(OFS_DELAY, 32'h3000);
        rd(OFS_DELAY, 32'h2710);
        for (int s = 0; s < 6; s++) begin
            wr(OFS_CTRL, s);
            bus(1'b0, OFS_STATUS, 32'h0);
            ck(q[10:8], s);
            ck(cmd_src_shown, s);
            if (s > 2) begin
                i_prt.host(3'h1 << (s - 3), 3'h1 << (s - 3));
                w(4);
                ck({run_cmd, reverse_cmd}, 2'b11);
                i_prt.host(3'h0, 3'h0);
                w(3);
            end
        end
        wr(8'h4C, 32'h1);
        wr(8'h54, 32'h2);
        wr(OFS_DELAY, 32'h2);
        wr(OFS_CTRL, 32'h1);
        i_prt.term(11'h008);
        w(5);
        ck(run_cmd, 0);
        w(9);
        ck({run_cmd, reverse_cmd}, 2'b10);
        i_prt.term(11'h028);
        w(5);
        ck(run_cmd, 0);
        i_prt.term(11'h020);
        w(16);
        ck({run_cmd, reverse_cmd}, 2'b11);
        i_prt.term(11'h000);
        wr(OFS_DELAY, 32'h0);
        for (int i = 0; i < 11; i++) begin
            wr(8'(64 + 4 * i), 32'h1);
            i_prt.term(11'h1 << i);
            w(4);
            ck(run_cmd, 1);
            i_prt.term(11'h000);
            wr(8'(64 + 4 * i), i == 5 ? 2 : i == 3 ? 1 : i < 3 ? 4 + i : 0);
        end
        i_prt.term(11'h001);
        w(4);
        ck({inch_fwd, inch_rev, premag_cmd}, 3'b100);
        i_prt.term(11'h006);
        w(4);
        ck({inch_fwd, inch_rev, premag_cmd}, 3'b011);
        i_prt.term(11'h000);
        for (int d = 0; d < 3; d++) begin
            wr(OFS_CTRL, 32'h1 | d << 4);
            for (int b = 0; b < 2; b++) begin
                i_prt.term(b ? 11'h020 : 11'h008);
                w(6);
                ck(run_cmd, d == 0 || b + d == 2);
                i_prt.term(11'h000);
                w(6);
            end
        end
        wr(OFS_CTRL, 32'h2);
        i_prt.term(11'h020);
        w(6);
        ck(run_cmd, 0);
        i_prt.term(11'h028);
        w(6);
        ck({run_cmd, reverse_cmd}, 2'b11);
        i_prt.term(11'h008);
        w(6);
        ck({run_cmd, reverse_cmd}, 2'b10);
        i_prt.term(11'h000);
        wr(OFS_CTRL, 32'h0);
        i_prt.press(0);
        ck({run_cmd, reverse_cmd}, 2'b10);
        i_prt.press(1);
        ck({run_cmd, reverse_cmd}, 2'b11);
        i_prt.press(2);
        ck(run_cmd, 0);
        wr(OFS_CTRL, 32'h81);
        i_prt.term(11'h008);
        w(6);
        i_prt.press(3);
        ck({remote_ind, run_cmd, freq_src_keypad}, 3'b001);
        i_prt.press(1);
        ck({run_cmd, reverse_cmd}, 2'b11);
        i_prt.press(3);
        ck({remote_ind, run_cmd, reverse_cmd}, 3'b110);
        rd(OFS_CTRL, 32'h81);
        i_prt.term(11'h000);
        wr(OFS_CTRL, 32'h83);
        i_prt.host(3'h1, 3'h0);
        i_prt.press(3);
        i_prt.press(3);
        ck(run_cmd, 0);
        i_prt.host(3'h0, 3'h0);
        i_prt.host(3'h1, 3'h1);
        w(4);
        ck({run_cmd, reverse_cmd}, 2'b11);
        i_prt.host(3'h0, 3'h0);
        wr(OFS_CTRL, 32'h1);
        i_prt.term(11'h008);
        w(6);
        trip_active <= 1'b1;
        w(4);
        ck(run_cmd, 0);
        trip_active <= 1'b0;
        trip_reset <= 1'b1;
        w(1);
        trip_reset <= 1'b0;
        w(1);
        ck(run_cmd, 0);
        w(9);
        ck(run_cmd, 0);
        i_prt.term(11'h000);
        w(6);
        i_prt.term(11'h008);
        w(6);
        ck(run_cmd, 1);
        for (int p = 1; p >= 0; p--) begin
            rst <= 1'b1;
            w(10);
            rst <= 1'b0;
            wr(8'h4C, 32'h1);
            wr(OFS_DELAY, 32'h0);
            wr(OFS_SRCH, 32'h10);
            wr(OFS_CTRL, 32'h1 | p << 3);
            w(3);
            ck(run_cmd, p);
            ck(ss_cnt, 1);
        end
        rd(OFS_STATUS, 32'h109);
        i_prt.term(11'h000);
        w(4);
        i_prt.term(11'h008);
        w(6);
        ck(run_cmd, 1);
        finish_test();
    end
endmodule
`default_nettype wire
